// ### rtl/eeprom_read_slave.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_read_slave #(
   parameter int unsigned WRITE_CYCLES = eeprom_rd_pkg::WRITE_TIME_CYC
) (
   // System clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Two-wire link
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   // Straps
   input  wire logic [2:0] i_chip_select_pins,
   input  wire logic       i_write_protect_input,
   // Status
   output logic            o_write_busy
);
   import eeprom_rd_pkg::*;

   localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WRITE_CYCLES - 1);

   // Storage, delivered erased; set at declaration so only the write process drives it
   localparam logic [CW_W-1:0] ERASED_CW = ecc_encode(ERASED_WORD);
   logic [CW_W-1:0] array_mem [ARRAY_WORDS] = '{default: ERASED_CW};
   logic [7:0]      id_mem    [ID_BYTES]    = '{default: ERASED_BYTE};

   // Link-side state
   link_state_t       state_q, state_d;
   rx_kind_t          kind_q, kind_d;
   logic [2:0]        bit_q, bit_d;
   logic [7:0]        shift_q, shift_d;
   logic [7:0]        tx_q, tx_d;
   logic [7:0]        ahi_q, ahi_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              ack_q, ack_d;
   logic              rw_q, rw_d;
   logic              id_q, id_d;
   logic              arm_q, arm_d;
   logic              start_seen_q, start_seen_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [LANES-1:0]  wmask_q, wmask_d;
   logic [ADDR_W-1:0] wbase_q, wbase_d;
   logic              wr_id_q, wr_id_d;
   logic              wr_lock_q, wr_lock_d;
   logic              oe_q, oe_d;
   // Edge-of-data domains
   logic              start_tgl_q, start_tgl_d;
   logic              wr_req_q, wr_req_d;
   // System-side state
   wr_state_t         w_q, w_d;
   logic [WCNT_W-1:0] wcnt_q, wcnt_d;
   logic              lock_q, lock_d;
   logic              busy_q, busy_d;
   logic              req_seen_q, req_seen_d;
   logic              req_s;
   // Synchronised into the link domain
   logic [5:0]        strap_s;
   logic [2:0]        cs_s;
   logic              wp_s;
   logic              busy_s;
   logic              lock_s;
   // Datapath
   logic [7:0]        rx_byte;
   logic [7:0]        rd_byte;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] old_word;
   logic [DATA_W-1:0] merged;
   logic              start_pend;
   logic              sel_ok;
   logic              mem_we;
   logic              id_we;
   logic              lock_bit;

   // Straps, busy and lock as levels on the link clock
   bit_sync #(.WIDTH(6)) u_link_sync (
      .i_clk   (i_scl),
      .i_rst_n (i_rst_n),
      .i_d     ({i_chip_select_pins, i_write_protect_input, busy_q, lock_q}),
      .o_q     (strap_s)
   );
   assign cs_s   = strap_s[5:3];
   assign wp_s   = strap_s[2];
   assign busy_s = strap_s[1];
   assign lock_s = strap_s[0];

   // Write request toggle into the system clock
   bit_sync #(.WIDTH(1)) u_req_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     (wr_req_q),
      .o_q     (req_s)
   );

   // Read data, corrected before it leaves
   ecc_fix u_rd_fix (
      .i_cw    (array_mem[addr_q[ADDR_W-1:2]]),
      .o_data  (rd_word),
      .o_fixed ()
   );
   ecc_fix u_wr_fix (
      .i_cw    (array_mem[wbase_q[ADDR_W-1:2]]),
      .o_data  (old_word),
      .o_fixed ()
   );

   // ID page uses only the low five address bits
   assign rd_byte = id_q ? id_mem[addr_q[4:0]]
                         : rd_word[{addr_q[1:0], 3'h0} +: 8];
   assign rx_byte = {shift_q[6:0], i_sda};
   // Start toggle settles while the clock is high, stable by the next rise
   assign start_pend = (start_tgl_q != start_seen_q);
   assign sel_ok = (rx_byte[7:4] == TYPE_ARRAY || rx_byte[7:4] == TYPE_ID)
                   && rx_byte[3:1] == cs_s && !busy_s;

   // Start: data falls while clock is high
   always_comb begin
      start_tgl_d = i_scl ? ~start_tgl_q : start_tgl_q;
   end
   always_ff @(negedge i_sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_tgl_q <= 1'b0;
      end else begin
         start_tgl_q <= start_tgl_d;
      end
   end

   // Stop: fires a write only if armed and no Start came since
   always_comb begin
      wr_req_d = wr_req_q;
      if (i_scl && arm_q && start_seen_q == start_tgl_q)
         wr_req_d = ~wr_req_q;
   end
   always_ff @(posedge i_sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_req_q <= 1'b0;
      end else begin
         wr_req_q <= wr_req_d;
      end
   end

   // Link sequencer, sampling on the rising clock
   always_comb begin
      state_d      = state_q;
      kind_d       = kind_q;
      bit_d        = bit_q;
      shift_d      = shift_q;
      tx_d         = tx_q;
      ahi_d        = ahi_q;
      addr_d       = addr_q;
      ack_d        = ack_q;
      rw_d         = rw_q;
      id_d         = id_q;
      arm_d        = 1'b0;
      start_seen_d = start_seen_q;
      wdata_d      = wdata_q;
      wmask_d      = wmask_q;
      wbase_d      = wbase_q;
      wr_id_d      = wr_id_q;
      wr_lock_d    = wr_lock_q;
      if (start_pend) begin
         start_seen_d = start_tgl_q;
         state_d      = S_RX;
         kind_d       = K_DEV;
         bit_d        = BIT_FIRST;
         shift_d      = {7'h00, i_sda};
      end else begin
         case (state_q)
            S_IDLE: begin
               state_d = S_IDLE;
            end
            S_RX: begin
               shift_d = rx_byte;
               bit_d   = bit_q + BIT_FIRST;
               // Stop falls in the slot after the data ack; stay armed through its rise
               if (kind_q == K_DATA && bit_q == BIT_ZERO)
                  arm_d = arm_q;
               if (bit_q == BIT_LAST) begin
                  state_d = S_ACK;
                  ack_d   = 1'b1;
                  case (kind_q)
                     K_DEV: begin
                        // Busy or foreign select: stay silent
                        if (!sel_ok)
                           state_d = S_IDLE;
                        id_d = (rx_byte[7:4] == TYPE_ID);
                        rw_d = rx_byte[0];
                     end
                     K_AHI: begin
                        ahi_d = rx_byte;
                     end
                     K_ALO: begin
                        // Upper bits beyond the array are ignored
                        addr_d    = {ahi_q[4:0], rx_byte};
                        wbase_d   = {ahi_q[4:0], rx_byte};
                        wmask_d   = '0;
                        wr_id_d   = id_q;
                        wr_lock_d = id_q && ahi_q[LOCK_AHI_BIT];
                     end
                     K_DATA: begin
                        // Write protect matters only here, never on reads
                        ack_d = id_q ? !lock_s : !wp_s;
                        if (ack_d) begin
                           wdata_d[{addr_q[1:0], 3'h0} +: 8] = rx_byte;
                           wmask_d[addr_q[1:0]] = 1'b1;
                           addr_d = addr_q + 13'h0001;
                        end
                     end
                     default: state_d = S_IDLE;
                  endcase
               end
            end
            S_ACK: begin
               bit_d = BIT_ZERO;
               if (!ack_q) begin
                  state_d = S_IDLE;
               end else begin
                  case (kind_q)
                     K_DEV: begin
                        // Ack after the write cycle continues the command
                        if (rw_q) begin
                           tx_d    = rd_byte;
                           state_d = S_TX;
                        end else begin
                           kind_d  = K_AHI;
                           state_d = S_RX;
                        end
                     end
                     K_AHI: begin
                        kind_d  = K_ALO;
                        state_d = S_RX;
                     end
                     K_ALO: begin
                        kind_d  = K_DATA;
                        state_d = S_RX;
                     end
                     default: begin
                        arm_d   = 1'b1;
                        state_d = S_RX;
                     end
                  endcase
               end
            end
            S_TX: begin
               tx_d  = {tx_q[6:0], 1'b0};
               bit_d = bit_q + BIT_FIRST;
               if (bit_q == BIT_LAST) begin
                  addr_d  = addr_q + 13'h0001;
                  state_d = S_MACK;
               end
            end
            S_MACK: begin
               bit_d = BIT_ZERO;
               if (!i_sda) begin
                  tx_d    = rd_byte;
                  state_d = S_TX;
               end else begin
                  state_d = S_IDLE;
               end
            end
            default: state_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q      <= S_IDLE;
         kind_q       <= K_DEV;
         bit_q        <= BIT_ZERO;
         shift_q      <= 8'h00;
         tx_q         <= 8'h00;
         ahi_q        <= 8'h00;
         addr_q       <= '0;
         ack_q        <= 1'b0;
         rw_q         <= 1'b0;
         id_q         <= 1'b0;
         arm_q        <= 1'b0;
         start_seen_q <= 1'b0;
         wdata_q      <= '0;
         wmask_q      <= '0;
         wbase_q      <= '0;
         wr_id_q      <= 1'b0;
         wr_lock_q    <= 1'b0;
      end else begin
         state_q      <= state_d;
         kind_q       <= kind_d;
         bit_q        <= bit_d;
         shift_q      <= shift_d;
         tx_q         <= tx_d;
         ahi_q        <= ahi_d;
         addr_q       <= addr_d;
         ack_q        <= ack_d;
         rw_q         <= rw_d;
         id_q         <= id_d;
         arm_q        <= arm_d;
         start_seen_q <= start_seen_d;
         wdata_q      <= wdata_d;
         wmask_q      <= wmask_d;
         wbase_q      <= wbase_d;
         wr_id_q      <= wr_id_d;
         wr_lock_q    <= wr_lock_d;
      end
   end

   // Data line driven on the falling clock; a pending Start releases it
   always_comb begin
      oe_d = 1'b0;
      if (state_q == S_ACK)
         oe_d = ack_q;
      else if (state_q == S_TX)
         oe_d = ~tx_q[7];
      oe_d = oe_d & ~start_pend;
   end
   always_ff @(negedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end
   assign o_sda_oe = oe_q;
   assign o_sda    = 1'b0;

   // Merge new bytes over the corrected old word
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         assign merged[g*8 +: 8] = wmask_q[g] ? wdata_q[g*8 +: 8] : old_word[g*8 +: 8];
      end
   endgenerate
   assign lock_bit = wdata_q[{wbase_q[1:0], 3'h0} + 5'(LOCK_DAT_BIT)];

   // Write cycle; latch is stable because nothing is acked meanwhile
   always_comb begin
      w_d        = w_q;
      wcnt_d     = wcnt_q;
      lock_d     = lock_q;
      req_seen_d = req_s;
      mem_we     = 1'b0;
      id_we      = 1'b0;
      case (w_q)
         W_IDLE: begin
            if (req_s != req_seen_q)
               w_d = W_PROG;
         end
         W_PROG: begin
            if (wr_lock_q)
               lock_d = lock_q | lock_bit;
            else if (wr_id_q)
               id_we = !lock_q;
            else
               mem_we = 1'b1;
            wcnt_d = '0;
            w_d    = W_WAIT;
         end
         W_WAIT: begin
            if (wcnt_q == WCNT_LAST)
               w_d = W_IDLE;
            else
               wcnt_d = wcnt_q + 17'h00001;
         end
         default: w_d = W_IDLE;
      endcase
      busy_d = (w_d != W_IDLE);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_q        <= W_IDLE;
         wcnt_q     <= '0;
         lock_q     <= 1'b0;
         busy_q     <= 1'b0;
         req_seen_q <= 1'b0;
      end else begin
         w_q        <= w_d;
         wcnt_q     <= wcnt_d;
         lock_q     <= lock_d;
         busy_q     <= busy_d;
         req_seen_q <= req_seen_d;
      end
   end
   assign o_write_busy = busy_q;

   // Cell programming: array takes the whole word with fresh check bits, ID page only the masked bytes, unencoded
   always_ff @(posedge i_clk) begin
      if (mem_we)
         array_mem[wbase_q[ADDR_W-1:2]] <= ecc_encode(merged);
      for (int i = 0; i < LANES; i++) begin
         if (id_we && wmask_q[i])
            id_mem[{wbase_q[4:2], 2'(i)}] <= wdata_q[i*8 +: 8];
      end
   end

   // Link checks
   a_ack_in_slot: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_ACK && ack_q && !start_pend) |-> o_sda_oe)
      else $error("ack not driven in ninth slot");
   a_tx_bit_out: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_TX && !start_pend) |-> (o_sda_oe == !tx_q[7]))
      else $error("data bit not on line");
   a_mack_release: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_MACK) |-> !o_sda_oe)
      else $error("line held in master ack slot");
   a_noack_idle: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_MACK && i_sda && !start_pend) |=> (state_q == S_IDLE))
      else $error("read went on after noack");
   a_addr_step: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_TX && bit_q == BIT_LAST && !start_pend)
      |=> (addr_q == 13'($past(addr_q) + 13'h0001)) ##1 (state_q != S_TX || bit_q == BIT_ZERO))
      else $error("address not advanced");
   a_busy_silent: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_RX && kind_q == K_DEV && bit_q == BIT_LAST && busy_s && !start_pend)
      |=> (state_q == S_IDLE) ##1 !o_sda_oe)
      else $error("select acked while busy");
   a_cs_match: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_RX && kind_q == K_DEV && bit_q == BIT_LAST && !start_pend
       && rx_byte[3:1] != cs_s) |=> (state_q == S_IDLE))
      else $error("foreign select acked");
   a_start_reset: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      start_pend |=> (state_q == S_RX && kind_q == K_DEV && bit_q == BIT_FIRST))
      else $error("start did not restart sequencing");
   a_id_lock_ack: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_RX && kind_q == K_DATA && id_q && bit_q == BIT_LAST && !start_pend)
      |=> (ack_q == !$past(lock_s)))
      else $error("id byte ack ignores lock");
   // System checks
   a_prog_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (w_q == W_IDLE && req_s != req_seen_q) |=> (w_q == W_PROG) ##1 (w_q == W_WAIT && busy_q))
      else $error("write cycle not started");

   c_seq_read: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_MACK && !i_sda) ##1 (state_q == S_TX));
   c_random_read: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_ACK && kind_q == K_ALO) ##[1:20] (state_q == S_TX));
   c_id_read: cover property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_q == S_TX && id_q));
   c_write_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      (w_q == W_PROG));
endmodule
`default_nettype wire

// ### include/eeprom_rd_pkg.sv
`default_nettype none
package eeprom_rd_pkg;
   localparam logic [3:0] TYPE_ARRAY   = 4'hA;
   localparam logic [3:0] TYPE_ID      = 4'hB;
   localparam int         ADDR_W       = 13;
   localparam int         ARRAY_WORDS  = 2048;
   localparam int         ID_BYTES     = 32;
   localparam int         DATA_W       = 32;
   localparam int         CHK_W        = 6;
   localparam int         CW_W         = 38;
   localparam int         LANES        = 4;
   localparam int         LOCK_AHI_BIT = 2;
   localparam int         LOCK_DAT_BIT = 1;
   localparam logic [2:0] BIT_ZERO     = 3'h0;
   localparam logic [2:0] BIT_FIRST    = 3'h1;
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam int unsigned WRITE_TIME_US = 5000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned WRITE_TIME_CYC = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int          WCNT_W        = 17;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_RX = 3'h1, S_ACK = 3'h3, S_TX = 3'h2, S_MACK = 3'h6
   } link_state_t;
   typedef enum logic [1:0] {
      K_DEV = 2'h0, K_AHI = 2'h1, K_ALO = 2'h3, K_DATA = 2'h2
   } rx_kind_t;
   typedef enum logic [1:0] {
      W_IDLE = 2'h0, W_PROG = 2'h1, W_WAIT = 2'h3
   } wr_state_t;

   // Hamming layout: check bits at power-of-two positions 1..32
   function automatic logic [CW_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
      logic [CW_W-1:0] cw;
      int              k;
      cw = '0;
      k  = 0;
      for (int p = 1; p <= CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p-1] = d[k];
            k++;
         end
      end
      for (int c = 0; c < CHK_W; c++) begin
         for (int p = 1; p <= CW_W; p++) begin
            if (((p >> c) & 1) == 1 && p != (1 << c))
               cw[(1<<c)-1] = cw[(1<<c)-1] ^ cw[p-1];
         end
      end
      return cw;
   endfunction

   function automatic logic [DATA_W-1:0] ecc_extract(input logic [CW_W-1:0] cw);
      logic [DATA_W-1:0] d;
      int                k;
      d = '0;
      k = 0;
      for (int p = 1; p <= CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = cw[p-1];
            k++;
         end
      end
      return d;
   endfunction
endpackage
`default_nettype wire

// ### rtl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // Levels in and out
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Two stages; the first is read by the second only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule
`default_nettype wire

// ### rtl/ecc_fix.sv
`timescale 1ns/1ps
`default_nettype none
module ecc_fix (
   // Stored codeword
   input  wire logic [eeprom_rd_pkg::CW_W-1:0]   i_cw,
   // Corrected data
   output logic      [eeprom_rd_pkg::DATA_W-1:0] o_data,
   output logic                                  o_fixed
);
   import eeprom_rd_pkg::*;

   logic [CHK_W-1:0] syn;
   logic [CW_W-1:0]  cw_fix;

   // Syndrome names the flipped position directly
   always_comb begin
      syn    = '0;
      cw_fix = i_cw;
      for (int p = 1; p <= CW_W; p++) begin
         if (i_cw[p-1])
            syn = syn ^ CHK_W'(p);
      end
      if (syn != '0 && int'(syn) <= CW_W)
         cw_fix[int'(syn)-1] = ~i_cw[int'(syn)-1];
      o_data  = ecc_extract(cw_fix);
      o_fixed = (syn != '0);
   end
endmodule
`default_nettype wire

// ### verification/link_master.sv
`timescale 1ns/1ps
`default_nettype none
module link_master (
   // Wire side
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   // Clock stands high, line released, between frames
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // One bit slot; data only moves while the clock is low
   task automatic slot(input logic b, output logic r);
      #3 o_sda_low <= ~b;
      #3 o_scl <= 1'b1;
      #6 r = i_sda;
      o_scl <= 1'b0;
   endtask
   // Works from idle and as a restart
   task automatic begin_frame();
      #3 o_sda_low <= 1'b0;
      #3 o_scl <= 1'b1;
      #6 o_sda_low <= 1'b1;
      #6 o_scl <= 1'b0;
   endtask
   task automatic end_frame();
      #3 o_sda_low <= 1'b1;
      #3 o_scl <= 1'b1;
      #6 o_sda_low <= 1'b0;
      #6;
   endtask
   // Send a byte, release the line for the answer
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) slot(d[i], r);
      slot(1'b1, r);
      ack = ~r;
   endtask
   // Take a byte; more low leaves it unacknowledged
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(~more, r);
   endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eeprom_rd_pkg::*;
   logic       i_clk = 1'b0;
   logic       i_rst_n = 1'b1;
   logic       wp = 1'b0;
   logic       scl;
   logic       m_low;
   logic       oe;
   logic       busy;
   wire logic  sda = ~(m_low | oe);
   int         n_mismatch = 0;
   int         compares = 0;
   always #25 i_clk = ~i_clk;
   link_master u_link_master (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   eeprom_read_slave #(.WRITE_CYCLES(20)) u_eeprom_read_slave (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(oe),
      .i_chip_select_pins(3'h5), .i_write_protect_input(wp), .o_write_busy(busy));
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Start (or restart) and a select byte for our strap value
   task automatic go(input logic [3:0] ty, input logic rw, output logic k);
      u_link_master.begin_frame();
      u_link_master.wbyte({ty, 3'h5, rw}, k);
   endtask
   task automatic put(input logic [7:0] d);
      logic k;
      u_link_master.wbyte(d, k);
      chk("byte ack", 8'h01, {7'h0, k});
   endtask
   task automatic rd(input logic more, input logic [7:0] e);
      logic [7:0] d;
      u_link_master.rbyte(more, d);
      chk("read byte", e, d);
   endtask
   task automatic t_write_poll();
      logic k;
      int   n;
      go(TYPE_ARRAY, 1'b0, k);
      put(8'h00);
      put(8'h00);
      put(8'h11);
      put(8'h22);
      put(8'h33);
      put(8'h44);
      u_link_master.end_frame();
      #200;
      chk("busy flag", 8'h01, {7'h0, busy});
      go(TYPE_ARRAY, 1'b0, k);
      chk("busy select", 8'h00, {7'h0, k});
      n = 0;
      while (k !== 1'b1 && n < 40) begin
         u_link_master.end_frame();
         go(TYPE_ARRAY, 1'b0, k);
         n++;
      end
      if (k !== 1'b1) begin
         chk("poll ack", 8'h01, {7'h0, k});
         stop_test();
      end
      put(8'hFF);
      put(8'hFF);
      go(TYPE_ARRAY, 1'b1, k);
      chk("read select", 8'h01, {7'h0, k});
      rd(1'b1, ERASED_BYTE);
      rd(1'b1, 8'h11);
      rd(1'b0, 8'h22);
      u_link_master.end_frame();
      $display("write and poll done");
   endtask
   // Write protect high must not disturb a read
   task automatic t_current();
      logic k;
      @(posedge i_clk) wp <= 1'b1;
      go(TYPE_ARRAY, 1'b1, k);
      chk("current select", 8'h01, {7'h0, k});
      rd(1'b0, 8'h33);
      u_link_master.end_frame();
      @(posedge i_clk) wp <= 1'b0;
      $display("current read done");
   endtask
   task automatic t_refuse();
      logic k;
      u_link_master.begin_frame();
      u_link_master.wbyte(8'h9B, k);
      chk("wrong type", 8'h00, {7'h0, k});
      u_link_master.begin_frame();
      u_link_master.wbyte({TYPE_ARRAY, 3'h2, 1'b1}, k);
      chk("wrong strap", 8'h00, {7'h0, k});
      u_link_master.end_frame();
      $display("refusal done");
   endtask
   task automatic t_id();
      logic k;
      go(TYPE_ID, 1'b0, k);
      put(8'hFB);
      put(8'hE3);
      go(TYPE_ID, 1'b1, k);
      rd(1'b0, ERASED_BYTE);
      go(TYPE_ID, 1'b0, k);
      put(8'h00);
      put(8'h00);
      put(8'h5A);
      u_link_master.begin_frame();
      u_link_master.end_frame();
      repeat (10) @(negedge i_clk);
      chk("no write after probe", 8'h00, {7'h0, busy});
      go(TYPE_ID, 1'b0, k);
      put(8'h04);
      put(8'h00);
      put(8'h02);
      u_link_master.end_frame();
      #2000;
      go(TYPE_ID, 1'b0, k);
      chk("ready select", 8'h01, {7'h0, k});
      put(8'h00);
      put(8'h00);
      u_link_master.wbyte(8'h5A, k);
      chk("locked probe", 8'h00, {7'h0, k});
      u_link_master.begin_frame();
      u_link_master.end_frame();
      $display("id page done");
   endtask
   initial begin
      i_rst_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      t_write_poll();
      t_current();
      t_refuse();
      t_id();
      stop_test();
   end
endmodule
`default_nettype wire
